/* verilog/mpfm_monitor.v */
// Motor protection monitor top: settings over AXI4-Lite, trip timers, fault latch, alarms.
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "mpfm_defines.vh"

module mpfm_monitor
#(
    parameter [33:0] IMB_CYCLES = `MPFM_IMB_PERSIST_S * `MPFM_CLK_HZ,
    parameter [33:0] GF_CYCLES = `MPFM_GF_PERSIST_S * `MPFM_CLK_HZ,
    parameter [33:0] TENTH_CYCLES = `MPFM_CLK_HZ / `MPFM_TENTHS_PER_S
)
(
    // Clock and reset
    input wire clock_i,
    input wire reset_n_i,
    // AXI4-Lite write address and data
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Phase measurements
    input wire [15:0] cur_a_i,
    input wire [15:0] cur_b_i,
    input wire [15:0] cur_c_i,
    input wire signed [15:0] inst_a_i,
    input wire signed [15:0] inst_b_i,
    input wire signed [15:0] inst_c_i,
    input wire [15:0] volt_a_i,
    input wire [15:0] volt_b_i,
    input wire [15:0] volt_c_i,
    input wire running_i,
    // Motor and relay outputs
    output wire stop_motor_o,
    output wire [5:0] fault_code_o,
    output wire imb_alarm_o,
    output wire volt_alarm_o,
    output wire gf_relay_o,
    output wire irq_o
);
    reg [5:0] imb_thr_q;
    reg [6:0] gf_thr_q;
    reg [5:0] ov_thr_q;
    reg [5:0] uv_thr_q;
    reg [9:0] vdelay_q;
    reg [15:0] full_load_amps_q;
    reg [15:0] rated_v_q;
    reg [3:0] irq_mask_q;
    reg [3:0] irq_stat_q;
    reg [3:0] irq_stat_d;
    reg fault_q;
    reg [5:0] fault_code_q;
    reg vfault_ov_q;
    reg vfault_uv_q;
    reg [1:0] vfault_phase_q;
    reg imb_alarm_q;
    reg volt_alarm_q;
    reg gf_cond_q;
    reg irq_q;

    reg aw_hold_q;
    reg [7:0] awaddr_q;
    reg w_hold_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;

    // Keeps the stored bytes whose strobe is low.
    function [15:0] merge16;
        input [15:0] old_v;
        input [15:0] new_v;
        input [1:0] strb;
        begin
            merge16[7:0] = strb[0] ? new_v[7:0] : old_v[7:0];
            merge16[15:8] = strb[1] ? new_v[15:8] : old_v[15:8];
        end
    endfunction

    // Imbalance detection.
    wire imb_over;
    wire imb_expired;

    mpfm_imbalance u_imbalance
    (
        .cur_a_i(cur_a_i),
        .cur_b_i(cur_b_i),
        .cur_c_i(cur_c_i),
        .full_load_amps_i(full_load_amps_q),
        .thr_i(imb_thr_q),
        .over_o(imb_over)
    );

    mpfm_persist_timer u_imb_timer
    (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .cond_i(imb_over),
        .limit_i(IMB_CYCLES),
        .expired_o(imb_expired)
    );

    // Ground fault from the instantaneous residual.
    wire signed [17:0] resid = {{2{inst_a_i[15]}}, inst_a_i} + {{2{inst_b_i[15]}}, inst_b_i}
        + {{2{inst_c_i[15]}}, inst_c_i};
    wire [17:0] resid_abs = resid[17] ? (18'h00000 - resid) : resid;
    wire [31:0] gf_lhs = {14'h0000, resid_abs} * `MPFM_PCT_FULL;
    wire [31:0] gf_rhs = {16'h0000, full_load_amps_q} * {25'h0000000, gf_thr_q};
    wire gf_over = (gf_thr_q != 7'h00) && (gf_lhs > gf_rhs);
    wire gf_expired;

    mpfm_persist_timer u_gf_timer
    (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .cond_i(gf_over),
        .limit_i(GF_CYCLES),
        .expired_o(gf_expired)
    );

    // Voltage checks against the rated line voltage, only while running.
    wire [31:0] ov_lim = {16'h0000, rated_v_q} * ({26'h0000000, ov_thr_q} + `MPFM_PCT_FULL);
    wire [31:0] uv_lim = {16'h0000, rated_v_q} * (`MPFM_PCT_FULL - {26'h0000000, uv_thr_q});
    wire [31:0] va100 = {16'h0000, volt_a_i} * `MPFM_PCT_FULL;
    wire [31:0] vb100 = {16'h0000, volt_b_i} * `MPFM_PCT_FULL;
    wire [31:0] vc100 = {16'h0000, volt_c_i} * `MPFM_PCT_FULL;
    wire ov_en = running_i && (ov_thr_q != 6'h00);
    wire uv_en = running_i && (uv_thr_q != 6'h00);
    wire [2:0] ov_ph = ov_en ? {vc100 > ov_lim, vb100 > ov_lim, va100 > ov_lim} : 3'h0;
    wire [2:0] uv_ph = uv_en ? {vc100 < uv_lim, vb100 < uv_lim, va100 < uv_lim} : 3'h0;
    wire volt_cond = (ov_ph != 3'h0) || (uv_ph != 3'h0);
    wire [2:0] v_ph = (ov_ph != 3'h0) ? ov_ph : uv_ph;
    wire [1:0] v_phase = v_ph[0] ? 2'h1 : (v_ph[1] ? 2'h2 : 2'h3);
    wire [33:0] vlimit = {24'h000000, vdelay_q} * TENTH_CYCLES;
    wire volt_expired;

    mpfm_persist_timer u_volt_timer
    (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .cond_i(volt_cond),
        .limit_i(vlimit),
        .expired_o(volt_expired)
    );

    // Register bus decode.
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_hold_q && w_hold_q && !bvalid_q;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire wr_ctrl = wr_go && (awaddr_q == `MPFM_OFF_CTRL) && wstrb_q[0];
    wire fault_clr = wr_ctrl && wdata_q[`MPFM_CTRL_FAULT_CLR];
    wire load_def = wr_ctrl && wdata_q[`MPFM_CTRL_LOAD_DEF];
    wire [15:0] wmerge_vd = merge16({6'h00, vdelay_q}, wdata_q[15:0], wstrb_q[1:0]);
    wire [15:0] wmerge_fla = merge16(full_load_amps_q, wdata_q[15:0], wstrb_q[1:0]);
    wire [15:0] wmerge_rv = merge16(rated_v_q, wdata_q[15:0], wstrb_q[1:0]);
    wire [7:0] wb = wdata_q[7:0];
    wire wr_lo = wr_go && wstrb_q[0];
    reg addr_ok;

    always @*
    begin
        case (awaddr_q)
            `MPFM_OFF_CTRL, `MPFM_OFF_IMB_THR, `MPFM_OFF_GF_THR, `MPFM_OFF_OV_THR,
            `MPFM_OFF_UV_THR, `MPFM_OFF_VDELAY, `MPFM_OFF_FLA, `MPFM_OFF_RATED_V,
            `MPFM_OFF_STATUS, `MPFM_OFF_IRQ_STAT, `MPFM_OFF_IRQ_MASK: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;

    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            aw_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            w_hold_q <= 1'b0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `MPFM_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= addr_ok ? `MPFM_RESP_OKAY : `MPFM_RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    // Settings; a value outside its legal range is ignored and the old one kept.
    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            imb_thr_q <= `MPFM_IMB_DEF;
            gf_thr_q <= `MPFM_GF_DEF;
            ov_thr_q <= `MPFM_OV_DEF;
            uv_thr_q <= `MPFM_UV_DEF;
            vdelay_q <= `MPFM_VDELAY_DEF;
            full_load_amps_q <= `MPFM_FLA_DEF;
            rated_v_q <= `MPFM_RATED_V_DEF;
            irq_mask_q <= `MPFM_IRQ_MASK_DEF;
        end
        else if (load_def)
        begin
            imb_thr_q <= `MPFM_IMB_DEF;
            gf_thr_q <= `MPFM_GF_DEF;
            ov_thr_q <= `MPFM_OV_DEF;
            uv_thr_q <= `MPFM_UV_DEF;
            vdelay_q <= `MPFM_VDELAY_DEF;
        end
        else if (wr_go)
        begin
            case (awaddr_q)
                `MPFM_OFF_IMB_THR:
                    if (wr_lo && wb[7:6] == 2'h0 && (wb[5:0] == 6'h00
                        || (wb[5:0] >= `MPFM_IMB_MIN && wb[5:0] <= `MPFM_IMB_MAX)))
                        imb_thr_q <= wb[5:0];
                `MPFM_OFF_GF_THR:
                    if (wr_lo && !wb[7] && (wb[6:0] == 7'h00
                        || (wb[6:0] >= `MPFM_GF_MIN && wb[6:0] <= `MPFM_GF_MAX)))
                        gf_thr_q <= wb[6:0];
                `MPFM_OFF_OV_THR:
                    if (wr_lo && wb[7:6] == 2'h0 && (wb[5:0] == 6'h00
                        || (wb[5:0] >= `MPFM_OV_MIN && wb[5:0] <= `MPFM_OV_MAX)))
                        ov_thr_q <= wb[5:0];
                `MPFM_OFF_UV_THR:
                    if (wr_lo && wb[7:6] == 2'h0 && (wb[5:0] == 6'h00
                        || (wb[5:0] >= `MPFM_UV_MIN && wb[5:0] <= `MPFM_UV_MAX)))
                        uv_thr_q <= wb[5:0];
                `MPFM_OFF_VDELAY:
                    if (wmerge_vd[15:10] == 6'h00 && wmerge_vd[9:0] >= `MPFM_VDELAY_MIN
                        && wmerge_vd[9:0] <= `MPFM_VDELAY_MAX)
                        vdelay_q <= wmerge_vd[9:0];
                `MPFM_OFF_FLA: full_load_amps_q <= wmerge_fla;
                `MPFM_OFF_RATED_V: rated_v_q <= wmerge_rv;
                `MPFM_OFF_IRQ_MASK:
                    if (wr_lo)
                        irq_mask_q <= wb[3:0];
                default: irq_mask_q <= irq_mask_q;
            endcase
        end
    end

    // Fault latch; the first fault holds until software clears it, a new trip beats the clear.
    wire any_trip = gf_expired || imb_expired || volt_expired;
    wire fault_new = any_trip && (!fault_q || fault_clr);

    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            fault_q <= 1'b0;
            fault_code_q <= `MPFM_FAULT_NONE;
            vfault_ov_q <= 1'b0;
            vfault_uv_q <= 1'b0;
            vfault_phase_q <= 2'h0;
        end
        else if (fault_new)
        begin
            fault_q <= 1'b1;
            vfault_ov_q <= 1'b0;
            vfault_uv_q <= 1'b0;
            vfault_phase_q <= 2'h0;
            if (gf_expired)
                fault_code_q <= `MPFM_FAULT_GF;
            else if (imb_expired)
                fault_code_q <= `MPFM_FAULT_IMB;
            else
            begin
                // Over-voltage wins when both are present on the same cycle.
                fault_code_q <= (ov_ph != 3'h0) ? `MPFM_FAULT_OV : `MPFM_FAULT_UV;
                vfault_ov_q <= (ov_ph != 3'h0);
                vfault_uv_q <= (ov_ph == 3'h0);
                vfault_phase_q <= v_phase;
            end
        end
        else if (fault_clr)
        begin
            fault_q <= 1'b0;
            fault_code_q <= `MPFM_FAULT_NONE;
            vfault_ov_q <= 1'b0;
            vfault_uv_q <= 1'b0;
            vfault_phase_q <= 2'h0;
        end
    end

    // Alarms and events; status bits clear on read, but a same-cycle event survives.
    wire rd_irq = ar_take && (s_axi_araddr == `MPFM_OFF_IRQ_STAT);
    wire [3:0] irq_ev;

    assign irq_ev[`MPFM_IRQ_FAULT] = fault_new;
    assign irq_ev[`MPFM_IRQ_IMB] = imb_over && !imb_alarm_q;
    assign irq_ev[`MPFM_IRQ_GF] = gf_over && !gf_cond_q;
    assign irq_ev[`MPFM_IRQ_VOLT] = volt_cond && !volt_alarm_q;

    always @*
    begin
        irq_stat_d = irq_stat_q;
        if (rd_irq)
            irq_stat_d = 4'h0;
        irq_stat_d = irq_stat_d | irq_ev;
    end

    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            imb_alarm_q <= 1'b0;
            volt_alarm_q <= 1'b0;
            gf_cond_q <= 1'b0;
            irq_stat_q <= 4'h0;
            irq_q <= 1'b0;
        end
        else
        begin
            imb_alarm_q <= imb_over;
            volt_alarm_q <= volt_cond;
            gf_cond_q <= gf_over;
            irq_stat_q <= irq_stat_d;
            irq_q <= (irq_stat_d & irq_mask_q) != 4'h0;
        end
    end

    // Register read path.
    reg [31:0] rd_mux;
    reg rd_ok;

    always @*
    begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `MPFM_OFF_CTRL: rd_mux = 32'h00000000;
            `MPFM_OFF_IMB_THR: rd_mux = {26'h0000000, imb_thr_q};
            `MPFM_OFF_GF_THR: rd_mux = {25'h0000000, gf_thr_q};
            `MPFM_OFF_OV_THR: rd_mux = {26'h0000000, ov_thr_q};
            `MPFM_OFF_UV_THR: rd_mux = {26'h0000000, uv_thr_q};
            `MPFM_OFF_VDELAY: rd_mux = {22'h000000, vdelay_q};
            `MPFM_OFF_FLA: rd_mux = {16'h0000, full_load_amps_q};
            `MPFM_OFF_RATED_V: rd_mux = {16'h0000, rated_v_q};
            `MPFM_OFF_STATUS: rd_mux = {18'h00000, fault_code_q, vfault_phase_q, vfault_uv_q,
                vfault_ov_q, volt_alarm_q, gf_cond_q, imb_alarm_q, fault_q};
            `MPFM_OFF_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_q};
            `MPFM_OFF_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_q};
            default: rd_ok = 1'b0;
        endcase
    end

    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `MPFM_RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_ok ? `MPFM_RESP_OKAY : `MPFM_RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign stop_motor_o = fault_q;
    assign fault_code_o = fault_code_q;
    assign imb_alarm_o = imb_alarm_q;
    assign volt_alarm_o = volt_alarm_q;
    assign gf_relay_o = gf_cond_q;
    assign irq_o = irq_q;
endmodule

/* common/mpfm_defines.vh */
// Register map, field layout, reset values and timing constants of the protection monitor.
`ifndef MPFM_DEFINES_VH
`define MPFM_DEFINES_VH

`define MPFM_ADDR_W 8
`define MPFM_OFF_CTRL 8'h00
`define MPFM_OFF_IMB_THR 8'h04
`define MPFM_OFF_GF_THR 8'h08
`define MPFM_OFF_OV_THR 8'h0C
`define MPFM_OFF_UV_THR 8'h10
`define MPFM_OFF_VDELAY 8'h14
`define MPFM_OFF_FLA 8'h18
`define MPFM_OFF_RATED_V 8'h1C
`define MPFM_OFF_STATUS 8'h20
`define MPFM_OFF_IRQ_STAT 8'h24
`define MPFM_OFF_IRQ_MASK 8'h28

`define MPFM_CTRL_FAULT_CLR 0
`define MPFM_CTRL_LOAD_DEF 1

`define MPFM_ST_FAULT 0
`define MPFM_ST_IMB_ALARM 1
`define MPFM_ST_GF_COND 2
`define MPFM_ST_VOLT_ALARM 3
`define MPFM_ST_VFAULT_OV 4
`define MPFM_ST_VFAULT_UV 5
`define MPFM_ST_PHASE_LO 6
`define MPFM_ST_CODE_LO 8

`define MPFM_IRQ_FAULT 0
`define MPFM_IRQ_IMB 1
`define MPFM_IRQ_GF 2
`define MPFM_IRQ_VOLT 3
`define MPFM_IRQ_W 4

`define MPFM_IMB_DEF 6'h0F
`define MPFM_IMB_MIN 6'h05
`define MPFM_IMB_MAX 6'h28
`define MPFM_GF_DEF 7'h00
`define MPFM_GF_MIN 7'h05
`define MPFM_GF_MAX 7'h64
`define MPFM_OV_DEF 6'h00
`define MPFM_OV_MIN 6'h01
`define MPFM_OV_MAX 6'h28
`define MPFM_UV_DEF 6'h00
`define MPFM_UV_MIN 6'h01
`define MPFM_UV_MAX 6'h28
`define MPFM_VDELAY_DEF 10'h001
`define MPFM_VDELAY_MIN 10'h001
`define MPFM_VDELAY_MAX 10'h384
`define MPFM_FLA_DEF 16'h0064
`define MPFM_RATED_V_DEF 16'h01E0
`define MPFM_IRQ_MASK_DEF 4'h0

`define MPFM_FAULT_NONE 6'h00
`define MPFM_FAULT_IMB 6'h25
`define MPFM_FAULT_GF 6'h26
`define MPFM_FAULT_OV 6'h30
`define MPFM_FAULT_UV 6'h31

`define MPFM_PCT_FULL 32'h00000064

`define MPFM_CLK_HZ 100000000
`define MPFM_IMB_PERSIST_S 10
`define MPFM_GF_PERSIST_S 3
`define MPFM_TENTHS_PER_S 10

`define MPFM_RESP_OKAY 2'h0
`define MPFM_RESP_SLVERR 2'h2

`endif

/* verilog/mpfm_persist_timer.v */
// Persistence timer: reports expiry once its condition has held for the limit in cycles.
`timescale 1ns/1ps
module mpfm_persist_timer
(
    // Clock and reset
    input wire clock_i,
    input wire reset_n_i,
    // Condition and limit
    input wire cond_i,
    input wire [33:0] limit_i,
    // Expiry level
    output wire expired_o
);
    reg [33:0] count_q;
    reg [33:0] count_d;

    // A condition that drops restarts the count from zero, so only unbroken persistence trips.
    always @*
    begin
        count_d = count_q;
        if (!cond_i)
            count_d = 34'h000000000;
        else if (count_q < limit_i)
            count_d = count_q + 34'h000000001;
    end

    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            count_q <= 34'h000000000;
        else
            count_q <= count_d;
    end

    assign expired_o = cond_i && (count_q >= limit_i);
endmodule

/* verilog/mpfm_imbalance.v */
// Current imbalance comparator working on sums to avoid any division.
`timescale 1ns/1ps
module mpfm_imbalance
(
    // Phase currents and full load amps
    input wire [15:0] cur_a_i,
    input wire [15:0] cur_b_i,
    input wire [15:0] cur_c_i,
    input wire [15:0] full_load_amps_i,
    // Threshold in percent, zero is off
    input wire [5:0] thr_i,
    // Imbalance above threshold
    output wire over_o
);
    wire [17:0] sum = {2'h0, cur_a_i} + {2'h0, cur_b_i} + {2'h0, cur_c_i};
    wire [17:0] a3 = {2'h0, cur_a_i} * 18'h00003;
    wire [17:0] b3 = {2'h0, cur_b_i} * 18'h00003;
    wire [17:0] c3 = {2'h0, cur_c_i} * 18'h00003;
    wire [17:0] fla3 = {2'h0, full_load_amps_i} * 18'h00003;
    wire [17:0] dev_a = (sum >= a3) ? sum - a3 : a3 - sum;
    wire [17:0] dev_b = (sum >= b3) ? sum - b3 : b3 - sum;
    wire [17:0] dev_c = (sum >= c3) ? sum - c3 : c3 - sum;
    wire [17:0] dev_ab = (dev_a >= dev_b) ? dev_a : dev_b;
    wire [17:0] dev_max = (dev_ab >= dev_c) ? dev_ab : dev_c;
    // All terms are scaled by three, so the average never needs a divide.
    wire [17:0] denom3 = (sum > fla3) ? sum : fla3;
    wire [31:0] lhs = {14'h0000, dev_max} * `MPFM_PCT_FULL;
    wire [31:0] rhs = {14'h0000, denom3} * {26'h0000000, thr_i};

    assign over_o = (thr_i != 6'h00) && (lhs > rhs);
endmodule

/* tb/mpfm_monitor_assertions.sv */
// Checker of trip timing and bus answers of the protection monitor.
`timescale 1ns/1ps
module mpfm_monitor_chk
#(
    parameter [33:0] IMB_CYCLES = 34'h32,
    parameter [33:0] GF_CYCLES = 34'h1E,
    parameter [33:0] TENTH_CYCLES = 34'hA
)
(
    // Clock, reset and bus
    input wire clock_i,
    input wire reset_n_i,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // Motor side
    input wire running_i,
    input wire stop_motor_o,
    input wire [5:0] fault_code_o,
    input wire imb_alarm_o,
    input wire volt_alarm_o,
    input wire gf_relay_o
);
    reg [33:0] imb_q, gf_q, volt_q;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    // Runs of each alarm; a trip must never come before its run is long enough.
    always @(posedge clock_i or negedge reset_n_i)
    begin
        imb_q <= (reset_n_i && imb_alarm_o) ? imb_q + 34'h1 : 34'h0;
        gf_q <= (reset_n_i && gf_relay_o) ? gf_q + 34'h1 : 34'h0;
        volt_q <= (reset_n_i && volt_alarm_o) ? volt_q + 34'h1 : 34'h0;
    end
    AST_CODE_KNOWN: assert property (stop_motor_o |-> fault_code_o inside
        {6'h25, 6'h26, 6'h30, 6'h31}) else $error("stop without a known code");
    AST_IMB_PERSIST: assert property ($rose(stop_motor_o) && fault_code_o == 6'h25
        |-> imb_q >= IMB_CYCLES - 34'h1) else $error("imbalance trip too early");
    AST_GF_PERSIST: assert property ($rose(stop_motor_o) && fault_code_o == 6'h26
        |-> gf_relay_o && gf_q >= GF_CYCLES - 34'h1) else $error("ground trip too early");
    AST_V_PERSIST: assert property ($rose(stop_motor_o) && fault_code_o[5:4] == 2'h3
        |-> volt_alarm_o && volt_q >= TENTH_CYCLES - 34'h1) else $error("voltage trip early");
    AST_V_IDLE: assert property (!running_i && !$past(running_i) |-> !volt_alarm_o)
        else $error("voltage alarm while stopped");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not withdrawn");
endmodule

/* tb/mpfm_plant.sv */
// Motor stage model: phase currents, line samples and voltages for a chosen load case.
`timescale 1ns/1ps
module mpfm_plant
(
    // Clock, load case and current level
    input wire clock_i,
    input wire [2:0] mode_i,
    input wire [15:0] base_i,
    // Phase measurements
    output reg [15:0] cur_a_o = 16'h0,
    output reg [15:0] cur_b_o = 16'h0,
    output reg [15:0] cur_c_o = 16'h0,
    output reg [15:0] inst_a_o = 16'h0,
    output reg [15:0] inst_b_o = 16'h0,
    output reg [15:0] inst_c_o = 16'h0,
    output reg [15:0] volt_a_o = 16'h0,
    output reg [15:0] volt_b_o = 16'h0,
    output reg [15:0] volt_c_o = 16'h0
);
    reg [7:0] ph_q = 8'h0;
    // Samples move every cycle so a stale residual cannot pass for a live one.
    always @(posedge clock_i)
    begin
        ph_q <= ph_q + 8'h7;
        cur_a_o <= base_i;
        cur_b_o <= base_i;
        cur_c_o <= (mode_i == 3'h1) ? base_i - 16'h1E : base_i;
        inst_a_o <= {8'h0, ph_q};
        inst_b_o <= 16'h0 - {8'h0, ph_q};
        inst_c_o <= (mode_i == 3'h2) ? 16'h14 : 16'h0;
        volt_a_o <= 16'h1E0;
        volt_b_o <= (mode_i == 3'h3) ? 16'h21C : 16'h1E0;
        volt_c_o <= (mode_i == 3'h4) ? 16'h1A4 : 16'h1E0;
    end
endmodule

/* tb/test_mpfm_monitor.sv */
// Self-checking bench of the protection monitor with a motor stage model.
`timescale 1ns/1ps
module test_mpfm_monitor;
    reg clock_i, reset_n_i, running_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg s_axi_arvalid, s_axi_rready;
    reg [7:0] s_axi_awaddr, s_axi_araddr;
    reg [31:0] s_axi_wdata;
    reg [2:0] mode;
    reg [15:0] base;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire stop, imb, volt, gf, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [5:0] code;
    wire [15:0] cur_a_i, cur_b_i, cur_c_i, inst_a_i, inst_b_i, inst_c_i, volt_a_i, volt_b_i, volt_c_i;
    integer err_count, comparisons, seed, i;
    reg [33:0] exp_q[$];
    mpfm_monitor #(.IMB_CYCLES(34'h32), .GF_CYCLES(34'h1E), .TENTH_CYCLES(34'hA)) dut_u
    (
        .clock_i, .reset_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cur_a_i, .cur_b_i, .cur_c_i, .inst_a_i,
        .inst_b_i, .inst_c_i, .volt_a_i, .volt_b_i, .volt_c_i, .running_i, .stop_motor_o(stop),
        .fault_code_o(code), .imb_alarm_o(imb), .volt_alarm_o(volt), .gf_relay_o(gf), .irq_o(irq)
    );
    mpfm_plant plant_u
    (
        .clock_i, .mode_i(mode), .base_i(base), .cur_a_o(cur_a_i), .cur_b_o(cur_b_i),
        .cur_c_o(cur_c_i), .inst_a_o(inst_a_i), .inst_b_o(inst_b_i), .inst_c_o(inst_c_i),
        .volt_a_o(volt_a_i), .volt_b_o(volt_b_i), .volt_c_o(volt_c_i)
    );
    initial
    begin
        clock_i = 1'h0;
        forever #5 clock_i = ~clock_i;
    end
    task chk(input [33:0] seen, input [33:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    begin
        @(posedge clock_i);
        exp_q.push_back({r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge clock_i);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    end
    endtask
    task rd(input [7:0] a, input [33:0] e);
    begin
        @(posedge clock_i);
        exp_q.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge clock_i);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
    end
    endtask
    task wrd(input [7:0] a, input [31:0] v, input [33:0] e);
    begin
        wr(a, v, 2'h0);
        rd(a, e);
    end
    endtask
    task trip(input [6:0] e);
    begin
        i = 0;
        while (!stop && i < 300)
        begin
            @(posedge clock_i);
            i = i + 1;
        end
        chk({stop, code}, e);
    end
    endtask
    task clear;
    begin
        mode <= 3'h0;
        wr(8'h0, 32'h1, 2'h0);
        repeat (2) @(posedge clock_i);
        chk(stop, 1'h0);
    end
    endtask
    task conclude;
    begin
        $display("Mismatches %0d in %0d comparisons", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    always @(posedge clock_i)
    begin
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
    end
    initial
    begin
        repeat (6000) @(posedge clock_i);
        err_count = err_count + 1;
        conclude;
    end
    initial
    begin
        seed = 32'h78E5;
        err_count = 0;
        comparisons = 0;
        reset_n_i = 1'h0;
        {running_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        mode = 3'h0;
        base = 16'h64;
        repeat (2) @(posedge clock_i);
        reset_n_i <= 1'h1;
        rd(8'h4, 34'hF);
        rd(8'h8, 34'h0);
        rd(8'h10, 34'h0);
        rd(8'h14, 34'h1);
        rd(8'h3C, {2'h2, 32'h0});
        wr(8'h3C, 32'h1, 2'h2);
        wrd(8'h4, 32'h4, 34'hF);
        wrd(8'h4, 32'h29, 34'hF);
        wrd(8'h8, 32'h65, 34'h0);
        wrd(8'h8, 32'h64, 34'h64);
        wrd(8'h10, 32'h29, 34'h0);
        wrd(8'h14, 32'h385, 34'h1);
        wrd(8'h14, 32'h384, 34'h384);
        wrd(8'h28, 32'h1, 34'h1);
        mode <= 3'h1;
        wrd(8'h4, 32'h14, 34'h14);
        repeat (80) @(posedge clock_i);
        chk({stop, imb}, 2'h0);
        wr(8'h4, 32'h13, 2'h0);
        repeat (20) @(posedge clock_i);
        chk(imb, 1'h1);
        mode <= 3'h0;
        repeat (3) @(posedge clock_i);
        chk(imb, 1'h0);
        mode <= 3'h1;
        trip(7'h65);
        chk(irq, 1'h1);
        rd(8'h20, 34'h2503);
        rd(8'h24, 34'h3);
        rd(8'h24, 34'h0);
        chk(irq, 1'h0);
        clear;
        base <= 16'h96;
        mode <= 3'h1;
        wr(8'h4, 32'hF, 2'h0);
        repeat (20) @(posedge clock_i);
        chk(imb, 1'h0);
        wr(8'h4, 32'hE, 2'h0);
        repeat (5) @(posedge clock_i);
        chk(imb, 1'h1);
        wr(8'h4, 32'h0, 2'h0);
        repeat (60) @(posedge clock_i);
        chk({stop, imb}, 2'h0);
        base <= 16'h50 + 16'($random(seed) & 32'h1F);
        mode <= 3'h2;
        wr(8'h0, 32'h2, 2'h0);
        rd(8'h4, 34'hF);
        repeat (40) @(posedge clock_i);
        chk({stop, gf}, 2'h0);
        wr(8'h8, 32'hA, 2'h0);
        repeat (3) @(posedge clock_i);
        chk(gf, 1'h1);
        trip(7'h66);
        clear;
        mode <= 3'h3;
        running_i <= 1'h1;
        repeat (20) @(posedge clock_i);
        chk({stop, volt}, 2'h0);
        running_i <= 1'h0;
        wr(8'hC, 32'hA, 2'h0);
        wr(8'h10, 32'hA, 2'h0);
        wr(8'h14, 32'h2, 2'h0);
        repeat (30) @(posedge clock_i);
        chk({stop, volt}, 2'h0);
        running_i <= 1'h1;
        trip(7'h70);
        rd(8'h20, 34'h3099);
        clear;
        mode <= 3'h4;
        trip(7'h71);
        rd(8'h20, 34'h31E9);
        conclude;
    end
endmodule
bind mpfm_monitor mpfm_monitor_chk #(.IMB_CYCLES(IMB_CYCLES), .GF_CYCLES(GF_CYCLES),
    .TENTH_CYCLES(TENTH_CYCLES)) chk_u (.clock_i, .reset_n_i, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .running_i, .stop_motor_o, .fault_code_o,
    .imb_alarm_o, .volt_alarm_o, .gf_relay_o);
